// ==== sim/mdio_station.sv ====
// Management station model that clocks clause-22 frames onto the data line.
`timescale 1ns/100ps
`default_nettype none
module mdio_station (
	input wire logic mclk_i,
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end

	// Data is set up while the clock is low and sampled just before it
	// rises, so the device's answer has most of a period to settle.
	task automatic bit_cyc(input logic oe, input logic v, output logic s);
		@(posedge mclk_i);
		mdio_oe_o <= oe;
		mdio_o <= v;
		repeat (5) @(posedge mclk_i);
		s = mdio_i;
		mdc_o <= 1'b1;
		repeat (5) @(posedge mclk_i);
		mdc_o <= 1'b0;
	endtask

	task automatic frame(input logic rd, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wv, output logic [15:0] rv);
		logic [63:0] f;
		logic s;
		rv = 16'h0000;
		f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wv};
		for (int i = 63; i >= 0; i--) begin
			bit_cyc(!rd || i > 17, f[i], s);
			if (i < 16)
				rv[i] = s;
		end
		@(posedge mclk_i);
		mdio_oe_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== sim/phy_loopback_crossover_error_regs_properties.sv ====
// Concurrent checks on the loopback, crossover and error register block.
`timescale 1ns/100ps
`default_nettype none
module lb_regs_checker #(
	parameter int MII_READY_CYCLES = 16
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic link_up_i,
	input wire logic mdix_o,
	input wire logic line_pair_one_tx_o,
	input wire logic [7:0] line_pair_tx_chan_o,
	input wire logic [7:0] line_pair_rx_chan_o,
	input wire logic [5:0] lb_mode_o,
	input wire logic tx_suppress_o,
	input wire logic link_status_o,
	input wire logic ready_for_data_o,
	input wire logic edpd_en_o,
	input wire logic edpd_nlp_en_o
);
	logic [15:0] mii_cnt_ff;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	// Counts cycles spent in the MII mode; saturates so it never wraps.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			mii_cnt_ff <= 16'h0000;
		else if (lb_mode_o != 6'h02)
			mii_cnt_ff <= 16'h0000;
		else if (mii_cnt_ff != 16'hffff)
			mii_cnt_ff <= mii_cnt_ff + 16'h0001;
	end

	// The edge that first sees reset low still shows reset-time outputs.
	sequence s_none2;
		!rst_i && lb_mode_o == 6'h01 ##1 lb_mode_o == 6'h01;
	endsequence
	sequence s_remote2;
		(lb_mode_o == 6'h20) [*2];
	endsequence
	sequence s_link2;
		(lb_mode_o inside {6'h04, 6'h08, 6'h10}) [*2] ##0
		$stable(link_status_o);
	endsequence

	chk_edpd_reset: assert property (
		$fell(rst_i) |=> edpd_en_o && edpd_nlp_en_o)
		else $error("energy detect enables not set after reset");
	chk_pair_follow: assert property (
		line_pair_one_tx_o == mdix_o)
		else $error("10/100 pair role differs from crossover");
	chk_gig_ab: assert property (
		line_pair_tx_chan_o[3:0] == (mdix_o ? 4'h1 : 4'h4))
		else $error("A/B channel mapping wrong");
	chk_rx_mirror: assert property (
		line_pair_rx_chan_o == {line_pair_tx_chan_o[5:4],
		line_pair_tx_chan_o[7:6], line_pair_tx_chan_o[1:0],
		line_pair_tx_chan_o[3:2]})
		else $error("receive channels do not mirror transmit");
	chk_tx_supp: assert property (
		tx_suppress_o |-> lb_mode_o == 6'h04)
		else $error("suppression outside digital loopback");
	chk_link_plain: assert property (
		s_none2 |-> link_status_o == $past(link_up_i))
		else $error("link status does not follow link");
	chk_remote_never: assert property (
		s_remote2 |-> !ready_for_data_o)
		else $error("ready in remote loopback");
	chk_ready_link: assert property (
		s_link2 |-> ready_for_data_o == link_status_o)
		else $error("ready differs from link status");
	chk_mii_wait: assert property (
		lb_mode_o == 6'h02 && ready_for_data_o |->
		mii_cnt_ff >= MII_READY_CYCLES - 2)
		else $error("ready too early in MII loopback");
endmodule

bind phy_loopback_crossover_error_regs lb_regs_checker #(
	.MII_READY_CYCLES(MII_READY_CYCLES)
) u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .link_up_i(link_up_i),
	.mdix_o(mdix_o), .line_pair_one_tx_o(line_pair_one_tx_o),
	.line_pair_tx_chan_o(line_pair_tx_chan_o),
	.line_pair_rx_chan_o(line_pair_rx_chan_o), .lb_mode_o(lb_mode_o),
	.tx_suppress_o(tx_suppress_o), .link_status_o(link_status_o),
	.ready_for_data_o(ready_for_data_o), .edpd_en_o(edpd_en_o),
	.edpd_nlp_en_o(edpd_nlp_en_o));
`default_nettype wire

// ==== sim/phy_loopback_crossover_error_regs_test.sv ====
// Self-checking bench for the loopback, crossover and error registers.
`timescale 1ns/100ps
`default_nettype none
module phy_loopback_crossover_error_regs_test;
	typedef struct packed {
		logic [4:0] ra;
		logic [15:0] wv;
		logic [2:0] lac;
		logic [15:0] ex;
	} row_type;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic lb_en = 1'b1, crc = 1'b0, sym = 1'b0, fc = 1'b0;
	logic ax = 1'b0, cd = 1'b0, lup = 1'b1;
	logic [15:0] ex;
	logic mdc, st_d, st_oe, dut_d, dut_oe, mdix, p1tx, sup, link, rdy;
	logic edpd, nlp;
	logic [7:0] txc, rxc;
	logic [5:0] mode;
	logic [15:0] rv;
	int n_mismatch = 0;
	int check_count = 0;
	// The line has a pull-up, so a released line reads high.
	wire logic mdio_w = dut_oe ? dut_d : (st_oe ? st_d : 1'b1);
	logic [15:0] cnt_exp [4] = '{16'h0003, 16'h0005, 16'h000a, 16'h000c};
	// Register, write value, {loopback_en, auto result, C/D swap}, expected.
	row_type rows [13] = '{
		{5'h13, 16'h0000, 3'h0, 16'h000b}, {5'h13, 16'h8001, 3'h4, 16'h0013},
		{5'h13, 16'he100, 3'h4, 16'h0011}, {5'h13, 16'h1040, 3'h4, 16'h0027},
		{5'h13, 16'h1000, 3'h4, 16'h0023}, {5'h13, 16'h0400, 3'h4, 16'h0043},
		{5'h13, 16'h0080, 3'h0, 16'h0083}, {5'h13, 16'h0200, 3'h0, 16'h0102},
		{5'h12, 16'h0400, 3'h2, 16'h03b1}, {5'h12, 16'h0200, 3'h0, 16'h03b1},
		{5'h12, 16'h0000, 3'h2, 16'h00e4}, {5'h12, 16'h0600, 3'h0, 16'h00e4},
		{5'h12, 16'h0000, 3'h1, 16'h00b4}};

	always #50 mclk_i = ~mclk_i;

	mdio_station st (.mclk_i(mclk_i), .mdio_i(mdio_w), .mdc_o(mdc),
		.mdio_o(st_d), .mdio_oe_o(st_oe));

	phy_loopback_crossover_error_regs #(.MII_READY_CYCLES(16)) DUT (
		.mclk_i(mclk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio_w),
		.mdio_o(dut_d), .mdio_oe_o(dut_oe), .loopback_en_i(lb_en),
		.link_up_i(lup), .crc_err_i(crc), .symbol_err_i(sym),
		.false_carrier_i(fc), .auto_mdix_i(ax), .cd_swap_i(cd),
		.mdix_o(mdix), .line_pair_one_tx_o(p1tx), .line_pair_tx_chan_o(txc),
		.line_pair_rx_chan_o(rxc), .lb_mode_o(mode), .tx_suppress_o(sup),
		.link_status_o(link), .ready_for_data_o(rdy), .edpd_en_o(edpd),
		.edpd_nlp_en_o(nlp));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] v);
		st.frame(1'b0, 5'h01, ra, v, rv);
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] ex);
		st.frame(1'b1, 5'h01, ra, 16'h0000, rv);
		chk(rv, ex);
	endtask

	task conclude;
		$display("mismatches=%0d checks=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk({4'h0, edpd, nlp, sup, mdix, txc}, 16'h0ee4);
		rd(5'h12, 16'h0400);
		rd(5'h13, 16'h1041);
		rd(5'h14, 16'h0000);
		rd(5'h15, 16'h000c);
		wr(5'h13, 16'hffff);
		rd(5'h13, 16'h96c1);
		wr(5'h15, 16'hfff3);
		rd(5'h15, 16'h0000);
		chk({14'h0, edpd, nlp}, 16'h0000);
		foreach (rows[i]) begin
			{lb_en, ax, cd} <= rows[i].lac;
			wr(rows[i].ra, rows[i].wv);
			repeat (30) @(posedge mclk_i);
			ex = rows[i].ex;
			if (rows[i].ra == 5'h13)
				chk({7'h0, mode, sup, link, rdy}, ex);
			else
				chk({6'h0, mdix, p1tx, txc}, ex);
		end
		// Real link drops: digital loopback follows it, forced MII does not.
		{lup, lb_en} <= 2'b01;
		wr(5'h13, 16'h1000);
		repeat (4) @(posedge mclk_i);
		chk({7'h0, mode, sup, link, rdy}, 16'h0020);
		wr(5'h13, 16'h8001);
		chk({15'h0, rdy}, 16'h0000);
		repeat (30) @(posedge mclk_i);
		chk({7'h0, mode, sup, link, rdy}, 16'h0013);
		lup <= 1'b1;
		// Each error kind lands in its own cycle, as coincident ones count once.
		for (int s = 0; s < 4; s++) begin
			wr(5'h12, {1'b0, s[1:0], 13'h0400});
			st.frame(1'b1, 5'h01, 5'h14, 16'h0000, rv);
			for (int i = 0; i < 15; i++) begin
				@(posedge mclk_i);
				crc <= i < 3;
				sym <= i >= 3 && i < 8;
				fc <= i >= 8;
			end
			@(posedge mclk_i);
			{crc, sym, fc} <= 3'h0;
			rd(5'h14, cnt_exp[s]);
		end
		rd(5'h14, 16'h0000);
		// A reset in mid-run must undo register writes and a pending count.
		fc <= 1'b1;
		@(posedge mclk_i);
		fc <= 1'b0;
		@(posedge mclk_i);
		{rst_i, lb_en, ax, cd} <= 4'hc;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk({4'h0, edpd, nlp, sup, mdix, txc}, 16'h0ee4);
		rd(5'h14, 16'h0000);
		rd(5'h12, 16'h0400);
		rd(5'h13, 16'h1041);
		rd(5'h15, 16'h000c);
		conclude;
	end

	initial begin
		repeat (60000) @(posedge mclk_i);
		n_mismatch++;
		conclude;
	end
endmodule
`default_nettype wire

// ==== src/err_cnt_if.sv ====
// Carrier between the register logic and the receive error counter.
`timescale 1ns/100ps
`default_nettype none
interface err_cnt_if;
	logic crc_err;
	logic symbol_err;
	logic false_carrier;
	logic sel_fc;
	logic sel_sym;
	logic clear;
	logic [15:0] count;
	modport counter (input crc_err, symbol_err, false_carrier, sel_fc,
		sel_sym, clear, output count);
	modport ctl (output crc_err, symbol_err, false_carrier, sel_fc,
		sel_sym, clear, input count);
endinterface
`default_nettype wire

// ==== src/phy_lb_defines.svh ====
// Register offsets, field positions, reset values and timing for the block.
`ifndef PHY_LB_DEFINES_SVH
`define PHY_LB_DEFINES_SVH

`define REG_CTRL2 5'h12
`define REG_LOOPBACK 5'h13
`define REG_RXERR 5'h14
`define REG_EDPD 5'h15

`define CTRL2_FC_BIT 14
`define CTRL2_SYM_BIT 13
`define CTRL2_AUTO_BIT 10
`define CTRL2_MAN_BIT 9
`define CTRL2_RST 16'h0400
`define CTRL2_MASK 16'h6600

`define LB_MII_BIT 15
`define LB_DIG_BIT 12
`define LB_LDRV_BIT 10
`define LB_REMOTE_BIT 9
`define LB_EXT_BIT 7
`define LB_TXSUP_BIT 6
`define LB_FORCE_BIT 0
`define LB_RST 16'h1041
`define LB_MASK 16'h96c1

`define EDPD_EN_BIT 3
`define EDPD_NLP_BIT 2
`define EDPD_RST 16'h000c
`define EDPD_MASK 16'h000c

`define RXERR_RST 16'h0000
`define RXERR_MAX 16'hffff

`define MDIO_PRE_LEN 6'h20
`define MDIO_HDR_LAST 6'h0b
`define MDIO_TA_LAST 6'h01
`define MDIO_DATA_LAST 6'h0f
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1

`define CHAN_A 2'h0
`define CHAN_B 2'h1
`define CHAN_C 2'h2
`define CHAN_D 2'h3

`define CLK_MHZ 10
`define MII_READY_US 2000
`define MII_READY_CYC (`MII_READY_US * `CLK_MHZ)

`endif

// ==== src/phy_lb_pkg.sv ====
// Types for the management frame receiver and the loopback mode decode.
package phy_lb_pkg;

	typedef enum logic [4:0] {
		FR_PRE = 5'h01,
		FR_START = 5'h02,
		FR_HDR = 5'h04,
		FR_TA = 5'h08,
		FR_DATA = 5'h10
	} frame_state_type;

	typedef enum logic [5:0] {
		LB_NONE = 6'h01,
		LB_MII = 6'h02,
		LB_DIGITAL = 6'h04,
		LB_LINE_DRV = 6'h08,
		LB_EXT_CABLE = 6'h10,
		LB_REMOTE = 6'h20
	} lb_mode_type;

endpackage

// ==== src/phy_loopback_crossover_error_regs.sv ====
// Management registers for error counting, crossover and loopback control.
`timescale 1ns/100ps
`default_nettype none
`include "phy_lb_defines.svh"
module phy_loopback_crossover_error_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int MII_READY_CYCLES = `MII_READY_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	input wire logic loopback_en_i,
	input wire logic link_up_i,
	input wire logic crc_err_i,
	input wire logic symbol_err_i,
	input wire logic false_carrier_i,
	input wire logic auto_mdix_i,
	input wire logic cd_swap_i,
	output logic mdix_o,
	output logic line_pair_one_tx_o,
	output logic [7:0] line_pair_tx_chan_o,
	output logic [7:0] line_pair_rx_chan_o,
	output logic [5:0] lb_mode_o,
	output logic tx_suppress_o,
	output logic link_status_o,
	output logic ready_for_data_o,
	output logic edpd_en_o,
	output logic edpd_nlp_en_o
);
	logic [2:0] mdc_sync_ff;
	logic [2:0] mdio_sync_ff;
	logic mdc_flt_ff;
	logic mdio_flt_ff;
	logic mdc_rise;
	logic mdio_bit;
	phy_lb_pkg::frame_state_type state_ff;
	logic [5:0] bit_cnt_ff;
	logic [15:0] shift_ff;
	logic [15:0] rd_shift_ff;
	logic is_read_ff;
	logic is_write_ff;
	logic [4:0] reg_addr_ff;
	logic hdr_done;
	logic hdr_match;
	logic [4:0] hdr_reg;
	logic hdr_ours;
	logic wr_pulse;
	logic [15:0] wr_data;
	logic [15:0] ctrl2_ff;
	logic [15:0] lb_ff;
	logic [15:0] edpd_ff;
	logic [15:0] rd_data;
	logic cnt_clear;
	logic [31:0] mii_timer_ff;
	logic mii_ready_ff;
	phy_lb_pkg::lb_mode_type mode;
	logic mdix;
	logic link_now;
	err_cnt_if cnt_bus ();

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mdc_sync_ff <= 3'h0;
			mdio_sync_ff <= 3'h7;
			mdc_flt_ff <= 1'b0;
			mdio_flt_ff <= 1'b1;
		end else begin
			mdc_sync_ff <= {mdc_sync_ff[1:0], mdc_i};
			mdio_sync_ff <= {mdio_sync_ff[1:0], mdio_i};
			if (mdc_sync_ff[1] == mdc_sync_ff[2]) begin
				mdc_flt_ff <= mdc_sync_ff[2];
			end
			if (mdio_sync_ff[1] == mdio_sync_ff[2]) begin
				mdio_flt_ff <= mdio_sync_ff[2];
			end
		end
	end

	assign mdc_rise = (mdc_sync_ff[1] == mdc_sync_ff[2]) & mdc_sync_ff[2] &
		~mdc_flt_ff;
	assign mdio_bit = mdio_flt_ff;
	assign hdr_done = mdc_rise && state_ff == phy_lb_pkg::FR_HDR &&
		bit_cnt_ff == `MDIO_HDR_LAST;
	assign hdr_reg = {shift_ff[3:0], mdio_bit};
	assign hdr_match = shift_ff[8:4] == PHY_ADDR;
	assign hdr_ours = hdr_reg == `REG_CTRL2 || hdr_reg == `REG_LOOPBACK ||
		hdr_reg == `REG_RXERR || hdr_reg == `REG_EDPD;
	assign wr_data = {shift_ff[14:0], mdio_bit};
	assign wr_pulse = mdc_rise && state_ff == phy_lb_pkg::FR_DATA &&
		bit_cnt_ff == `MDIO_DATA_LAST && is_write_ff;
	// The count is captured and cleared as its read frame is decoded.
	assign cnt_clear = hdr_done && hdr_match && hdr_reg == `REG_RXERR &&
		shift_ff[10:9] == `MDIO_OP_READ;

	always_comb begin
		case (hdr_reg)
			`REG_CTRL2: rd_data = ctrl2_ff;
			`REG_LOOPBACK: rd_data = lb_ff;
			`REG_RXERR: rd_data = cnt_bus.count;
			`REG_EDPD: rd_data = edpd_ff;
			default: rd_data = 16'h0000;
		endcase
	end

	// Management frame receiver: 32 ones, start, op, addresses, turnaround.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= phy_lb_pkg::FR_PRE;
			bit_cnt_ff <= 6'h00;
			shift_ff <= 16'h0000;
			is_read_ff <= 1'b0;
			is_write_ff <= 1'b0;
			reg_addr_ff <= 5'h00;
		end else if (mdc_rise) begin
			shift_ff <= {shift_ff[14:0], mdio_bit};
			bit_cnt_ff <= bit_cnt_ff + 6'h01;
			case (state_ff)
				phy_lb_pkg::FR_PRE: begin
					if (mdio_bit) begin
						if (bit_cnt_ff == `MDIO_PRE_LEN) begin
							bit_cnt_ff <= bit_cnt_ff;
						end
					end else begin
						bit_cnt_ff <= 6'h00;
						if (bit_cnt_ff == `MDIO_PRE_LEN) begin
							state_ff <= phy_lb_pkg::FR_START;
						end
					end
				end
				phy_lb_pkg::FR_START: begin
					bit_cnt_ff <= 6'h00;
					state_ff <= mdio_bit ? phy_lb_pkg::FR_HDR :
						phy_lb_pkg::FR_PRE;
				end
				phy_lb_pkg::FR_HDR: begin
					if (hdr_done) begin
						bit_cnt_ff <= 6'h00;
						state_ff <= phy_lb_pkg::FR_TA;
						reg_addr_ff <= hdr_reg;
						is_read_ff <= hdr_match && hdr_ours &&
							shift_ff[10:9] == `MDIO_OP_READ;
						is_write_ff <= hdr_match && hdr_ours &&
							shift_ff[10:9] == `MDIO_OP_WRITE;
					end
				end
				phy_lb_pkg::FR_TA: begin
					if (bit_cnt_ff == `MDIO_TA_LAST) begin
						bit_cnt_ff <= 6'h00;
						state_ff <= phy_lb_pkg::FR_DATA;
					end
				end
				phy_lb_pkg::FR_DATA: begin
					if (bit_cnt_ff == `MDIO_DATA_LAST) begin
						bit_cnt_ff <= 6'h00;
						state_ff <= phy_lb_pkg::FR_PRE;
						is_read_ff <= 1'b0;
						is_write_ff <= 1'b0;
					end
				end
				default: begin
					bit_cnt_ff <= 6'h00;
					state_ff <= phy_lb_pkg::FR_PRE;
				end
			endcase
		end
	end

	// Read data leaves on each rising clock so it is stable at the next.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_shift_ff <= 16'h0000;
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end else if (mdc_rise) begin
			if (hdr_done) begin
				rd_shift_ff <= rd_data;
			end else if (state_ff == phy_lb_pkg::FR_TA && is_read_ff) begin
				if (bit_cnt_ff == `MDIO_TA_LAST) begin
					mdio_o <= rd_shift_ff[15];
					rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
				end else begin
					mdio_o <= 1'b0;
					mdio_oe_o <= 1'b1;
				end
			end else if (state_ff == phy_lb_pkg::FR_DATA && is_read_ff) begin
				mdio_o <= rd_shift_ff[15];
				rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
				if (bit_cnt_ff == `MDIO_DATA_LAST) begin
					mdio_oe_o <= 1'b0;
					mdio_o <= 1'b0;
				end
			end else begin
				mdio_oe_o <= 1'b0;
				mdio_o <= 1'b0;
			end
		end
	end

	// Writable registers; masks keep reserved bits at zero.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl2_ff <= `CTRL2_RST;
			lb_ff <= `LB_RST;
			edpd_ff <= `EDPD_RST;
		end else if (wr_pulse) begin
			case (reg_addr_ff)
				`REG_CTRL2: ctrl2_ff <= wr_data & `CTRL2_MASK;
				`REG_LOOPBACK: lb_ff <= wr_data & `LB_MASK;
				`REG_EDPD: edpd_ff <= wr_data & `EDPD_MASK;
				default: ctrl2_ff <= ctrl2_ff;
			endcase
		end
	end

	assign cnt_bus.crc_err = crc_err_i;
	assign cnt_bus.symbol_err = symbol_err_i;
	assign cnt_bus.false_carrier = false_carrier_i;
	assign cnt_bus.sel_fc = ctrl2_ff[`CTRL2_FC_BIT];
	assign cnt_bus.sel_sym = ctrl2_ff[`CTRL2_SYM_BIT];
	assign cnt_bus.clear = cnt_clear;

	rx_error_counter u_rx_error_counter (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.cnt_if(cnt_bus.counter)
	);

	// The general loopback bit splits near-end modes from far-end ones.
	always_comb begin
		if (loopback_en_i) begin
			if (lb_ff[`LB_MII_BIT]) begin
				mode = phy_lb_pkg::LB_MII;
			end else if (lb_ff[`LB_DIG_BIT]) begin
				mode = phy_lb_pkg::LB_DIGITAL;
			end else if (lb_ff[`LB_LDRV_BIT]) begin
				mode = phy_lb_pkg::LB_LINE_DRV;
			end else begin
				mode = phy_lb_pkg::LB_NONE;
			end
		end else if (lb_ff[`LB_REMOTE_BIT]) begin
			mode = phy_lb_pkg::LB_REMOTE;
		end else if (lb_ff[`LB_EXT_BIT]) begin
			mode = phy_lb_pkg::LB_EXT_CABLE;
		end else begin
			mode = phy_lb_pkg::LB_NONE;
		end
	end

	assign mdix = ctrl2_ff[`CTRL2_AUTO_BIT] ? auto_mdix_i :
		ctrl2_ff[`CTRL2_MAN_BIT];
	assign link_now = mode == phy_lb_pkg::LB_MII ?
		lb_ff[`LB_FORCE_BIT] : link_up_i;

	// Settling timer restarts on every entry into MII loopback.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mii_timer_ff <= 32'h0;
			mii_ready_ff <= 1'b0;
		end else if (mode != phy_lb_pkg::LB_MII) begin
			mii_timer_ff <= 32'h0;
			mii_ready_ff <= 1'b0;
		end else if (mii_timer_ff == 32'(MII_READY_CYCLES - 1)) begin
			mii_ready_ff <= 1'b1;
		end else begin
			mii_timer_ff <= mii_timer_ff + 32'h1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mdix_o <= 1'b0;
			line_pair_one_tx_o <= 1'b0;
			line_pair_tx_chan_o <= {`CHAN_D, `CHAN_C, `CHAN_B, `CHAN_A};
			line_pair_rx_chan_o <= {`CHAN_C, `CHAN_D, `CHAN_A, `CHAN_B};
			lb_mode_o <= phy_lb_pkg::LB_NONE;
			tx_suppress_o <= 1'b0;
			link_status_o <= 1'b0;
			ready_for_data_o <= 1'b0;
			edpd_en_o <= 1'b0;
			edpd_nlp_en_o <= 1'b0;
		end else begin
			mdix_o <= mdix;
			line_pair_one_tx_o <= mdix;
			// Pairs one/zero swap A/B under MDI-X; a detected C/D swap is
			// corrected whether crossover is forced or automatic.
			line_pair_tx_chan_o[3:0] <= mdix ? {`CHAN_A, `CHAN_B} :
				{`CHAN_B, `CHAN_A};
			line_pair_rx_chan_o[3:0] <= mdix ? {`CHAN_B, `CHAN_A} :
				{`CHAN_A, `CHAN_B};
			line_pair_tx_chan_o[7:4] <= (mdix ^ cd_swap_i) ?
				{`CHAN_C, `CHAN_D} : {`CHAN_D, `CHAN_C};
			line_pair_rx_chan_o[7:4] <= (mdix ^ cd_swap_i) ?
				{`CHAN_D, `CHAN_C} : {`CHAN_C, `CHAN_D};
			lb_mode_o <= mode;
			tx_suppress_o <= mode == phy_lb_pkg::LB_DIGITAL &&
				lb_ff[`LB_TXSUP_BIT];
			link_status_o <= link_now;
			case (mode)
				phy_lb_pkg::LB_MII: ready_for_data_o <= mii_ready_ff;
				phy_lb_pkg::LB_REMOTE: ready_for_data_o <= 1'b0;
				default: ready_for_data_o <= link_now;
			endcase
			edpd_en_o <= edpd_ff[`EDPD_EN_BIT];
			edpd_nlp_en_o <= edpd_ff[`EDPD_NLP_BIT];
		end
	end
endmodule
`default_nettype wire

// ==== src/rx_error_counter.sv ====
// Sixteen-bit receive error counter with selectable error sources.
`timescale 1ns/100ps
`default_nettype none
`include "phy_lb_defines.svh"
module rx_error_counter (
	input wire logic mclk_i,
	input wire logic rst_i,
	err_cnt_if.counter cnt_if
);
	logic [15:0] count_ff;
	logic [15:0] nxt_count;
	logic hit;

	// Symbol select swaps CRC for symbol errors; false carrier adds on.
	always_comb begin
		hit = (cnt_if.sel_sym ? cnt_if.symbol_err : cnt_if.crc_err) |
			(cnt_if.sel_fc & cnt_if.false_carrier);
		if (cnt_if.clear) begin
			// An error in the clearing cycle is kept as the first count.
			nxt_count = hit ? 16'h0001 : `RXERR_RST;
		end else if (hit && count_ff != `RXERR_MAX) begin
			nxt_count = count_ff + 16'h0001;
		end else begin
			nxt_count = count_ff;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= `RXERR_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign cnt_if.count = count_ff;
endmodule
`default_nettype wire
